// File: hdl/tgd_pkg.sv
// package: shared constants and types for the three-phase gate drive pair
package tgd_pkg;
  localparam int TGD_PHASES = 3;
  // clock rate and dead-time timing
  localparam int TGD_CLK_MHZ = 125;
  localparam int TGD_DEAD_STEP_NS = 250;
  localparam int TGD_DEAD_STEP_CYC = (TGD_DEAD_STEP_NS * TGD_CLK_MHZ + 999) / 1000;
  localparam logic [2:0] TGD_DEAD_SEL_DEFAULT = 3'h7; // 2000 ns
  localparam int TGD_DEAD_CNT_W = 9; // must hold 8 steps of 32 cycles
  // gate bias filter time (least time, rounded up)
  localparam int TGD_BIAS_FILTER_NS = 1000;
  localparam int TGD_BIAS_FILTER_CYC = (TGD_BIAS_FILTER_NS * TGD_CLK_MHZ + 999) / 1000;
  localparam int TGD_BIAS_CNT_W = 12;
  // bootstrap hold per microfarad
  localparam int TGD_BOOT_US_PER_UF = 1200;
  localparam int TGD_BOOT_CYC_PER_UF = TGD_BOOT_US_PER_UF * TGD_CLK_MHZ;
  localparam int TGD_TIME_W = 24;
  // pattern bit positions: {hc,hb,ha,lc,lb,la}
  localparam logic [5:0] TGD_PAT_OFF = 6'h00;
  localparam logic [5:0] TGD_PAT_BOOT = 6'h07;
  localparam logic [5:0] TGD_PAT_LOCK = 6'h2a; // ha hc high, lb low
  localparam logic [5:0] TGD_PAT_S1 = 6'h0c; // a/c
  localparam logic [5:0] TGD_PAT_S2 = 6'h14; // b/c
  localparam logic [5:0] TGD_PAT_S3 = 6'h11; // b/a
  localparam logic [5:0] TGD_PAT_S4 = 6'h21; // c/a
  localparam logic [5:0] TGD_PAT_S5 = 6'h22; // c/b
  localparam logic [5:0] TGD_PAT_S6 = 6'h0a; // a/b
  localparam logic [2:0] TGD_STEP_FIRST = 3'h0;
  localparam logic [2:0] TGD_STEP_LAST = 3'h5;
  typedef enum logic [2:0] {
    TGD_DISABLED, TGD_BOOTSTRAP, TGD_LOCK, TGD_RAMP, TGD_RUN
  } tgd_mode_t;
endpackage : tgd_pkg

// File: hdl/tgd_link_if.sv
// interface: gate inputs, chip enable and fault line between host and driver
`timescale 1ns/1ps
`default_nettype none
interface tgd_link_if;
  logic [2:0] high_drive;
  logic [2:0] low_drive;
  logic chip_enable;
  logic fault_out_oe; // open drain: low while enabled
  logic fault_output_pin;
  assign fault_output_pin = fault_out_oe ? 1'b0 : 1'b1;
  modport host (output high_drive, output low_drive, output chip_enable, input fault_output_pin);
  modport dev (input high_drive, input low_drive, input chip_enable, output fault_out_oe);
endinterface : tgd_link_if
`default_nettype wire

// File: hdl/tgd_half_bridge.sv
// module: one half-bridge with interlock, dead time and gate bias lockout
`timescale 1ns/1ps
`default_nettype none
module tgd_half_bridge
  import tgd_pkg::*;
#(
  parameter int FILTER_CYC = TGD_BIAS_FILTER_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic run_ok,
  input wire logic hi_in,
  input wire logic lo_in,
  input wire logic [2:0] dead_time_select,
  input wire logic uv_enable,
  input wire logic hi_bias_low,
  input wire logic lo_bias_low,
  output logic hi_gate,
  output logic lo_gate,
  output logic uv_fault
);
  logic [TGD_DEAD_CNT_W-1:0] dead_reg;
  logic [TGD_BIAS_CNT_W-1:0] uvcnt_reg;
  logic hi_reg, lo_reg, uv_reg;
  // both commanded on means both off
  wire both_on = hi_in & lo_in; // [R21]
  wire want_hi = run_ok & hi_in & ~both_on & ~uv_reg; // [R12] [R14]
  wire want_lo = run_ok & lo_in & ~both_on & ~uv_reg; // [R12] [R14]
  wire [TGD_DEAD_CNT_W-1:0] dead_load =
    TGD_DEAD_CNT_W'((32'(dead_time_select) + 32'd1) * TGD_DEAD_STEP_CYC); // [R22]
  wire dead_done = (dead_reg == '0);
  // a side may only turn on once the other has been off for the full dead time
  wire hi_next = want_hi & (hi_reg | (~lo_reg & dead_done)); // [R22]
  wire lo_next = want_lo & (lo_reg | (~hi_reg & dead_done)); // [R22]
  // only count undervoltage while a gate is actually driven
  wire bias_low = (hi_reg & hi_bias_low) | (lo_reg & lo_bias_low); // [R13]
  always_ff @(posedge clk) begin
    if (!rst_b || !run_ok) begin
      hi_reg <= 1'b0; // [R2]
      lo_reg <= 1'b0; // [R2]
    end else begin
      hi_reg <= hi_next; // [R10]
      lo_reg <= lo_next; // [R10]
    end
  end
  // dead counter reloads whenever either gate is on
  always_ff @(posedge clk) begin
    if (!rst_b) dead_reg <= '0;
    else if (hi_reg | lo_reg) dead_reg <= dead_load;
    else if (!dead_done) dead_reg <= dead_reg - 1'b1;
  end
  // lockout filter; fault clears only through the enable cycling
  always_ff @(posedge clk) begin
    if (!rst_b || !run_ok) begin
      uvcnt_reg <= '0;
      uv_reg <= 1'b0; // [R16]
    end else begin
      if (uv_enable && bias_low) begin // [R17]
        if (uvcnt_reg > TGD_BIAS_CNT_W'(FILTER_CYC)) uv_reg <= 1'b1; // [R14] [R16]
        else uvcnt_reg <= uvcnt_reg + 1'b1;
      end else begin
        uvcnt_reg <= '0;
      end
    end
  end
  assign hi_gate = hi_reg;
  assign lo_gate = lo_reg;
  assign uv_fault = uv_reg;
endmodule : tgd_half_bridge
`default_nettype wire

// File: hdl/tgd_driver.sv
// module: the gate driver end; synchronises inputs and drives three half-bridges
//
// Operation
// R1: host steps disabled, bootstrap, lock, ramp, run
// R2: chip enable low holds all gates low
// R3: bootstrap: all low sides on, timed
// R4: no high side before bootstrap charge
// R5: lock: high A and C, low B
// R6: hold lock until load settles
// R7: ramp: open-loop steps at rising rate
// R8: run: commutation timed from back EMF
// R9: six commutation states, order sets direction
// R10: each gate follows its own input
// R11: undriven gate input reads as off
// R12: fault or disable forces gates low
// R13: undervoltage watched only while driving
// R14: filtered undervoltage blocks driver, raises fault
// R15: fault shown on pin and status
// R16: fault latched until enable cycled
// R17: undervoltage check only when enabled
// R18: chop-chop accelerating, chop-coast steady
// R19: chop-coast modulates high sides only
// R20: chop-chop reference about nine percent lower; host uses the same duty in both chop modes
// R21: both sides commanded on: both off
// R22: selectable break-before-make dead time
// R23: inputs registered before gate logic
`timescale 1ns/1ps
`default_nettype none
module tgd_driver
  import tgd_pkg::*;
#(
  parameter int FILTER_CYC = TGD_BIAS_FILTER_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  tgd_link_if.dev link,
  input wire logic [2:0] dead_time_select,
  input wire logic gate_undervoltage_enable,
  input wire logic [2:0] high_bias_low,
  input wire logic [2:0] low_bias_low,
  output logic [2:0] high_gate,
  output logic [2:0] low_gate,
  output logic driver_fault
);
  // three-stage synchronisers; a pin change counts when stages 2 and 3 agree
  logic [6:0] s1_reg, s2_reg, s3_reg, in_reg;
  // the synchroniser resets to zero, so idle reads as off
  wire [6:0] pins = {link.chip_enable, link.low_drive, link.high_drive}; // [R11]
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      in_reg <= '0;
    end else begin
      s1_reg <= pins; // [R23]
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      in_reg <= (s2_reg & s3_reg) | (in_reg & (s2_reg | s3_reg)); // [R23]
    end
  end
  wire ce_sync = in_reg[6];
  wire [2:0] hi_sync = in_reg[2:0];
  wire [2:0] lo_sync = in_reg[5:3];
  logic [2:0] uv_bits;
  logic [2:0] hg, lg;
  logic fault_reg;
  wire any_fault = |uv_bits;
  wire run_ok = ce_sync & ~fault_reg; // [R12] [R2]
  genvar i;
  generate
    for (i = 0; i < TGD_PHASES; i++) begin : g_phase
      tgd_half_bridge #(.FILTER_CYC(FILTER_CYC)) u_hb (
        .clk(clk),
        .rst_b(rst_b),
        .run_ok(ce_sync),
        .hi_in(hi_sync[i] & ~fault_reg),
        .lo_in(lo_sync[i] & ~fault_reg),
        .dead_time_select(dead_time_select),
        .uv_enable(gate_undervoltage_enable),
        .hi_bias_low(high_bias_low[i]),
        .lo_bias_low(low_bias_low[i]),
        .hi_gate(hg[i]),
        .lo_gate(lg[i]),
        .uv_fault(uv_bits[i])
      );
    end
  endgenerate
  // any half-bridge fault shuts down all three until enable is cycled
  always_ff @(posedge clk) begin
    if (!rst_b || !ce_sync) fault_reg <= 1'b0; // [R16]
    else if (any_fault) fault_reg <= 1'b1; // [R16]
  end
  // outputs registered; gates gated once more so a new fault blocks at once
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      high_gate <= '0;
      low_gate <= '0;
      driver_fault <= 1'b0;
      link.fault_out_oe <= 1'b0;
    end else begin
      high_gate <= run_ok ? hg : 3'h0; // [R12]
      low_gate <= run_ok ? lg : 3'h0; // [R12]
      driver_fault <= fault_reg; // [R15]
      link.fault_out_oe <= fault_reg; // [R15]
    end
  end
endmodule : tgd_driver
`default_nettype wire

// File: hdl/tgd_host.sv
// module: host end; start-up mode sequence, six-step commutation and pwm
`timescale 1ns/1ps
`default_nettype none
module tgd_host
  import tgd_pkg::*;
#(
  parameter int BOOT_UF = 1,
  parameter int BOOT_CYC = TGD_BOOT_CYC_PER_UF * BOOT_UF,
  parameter int LOCK_CYC = 125000,
  parameter int RAMP_START_CYC = 100000,
  parameter int RAMP_DEC_CYC = 1000,
  parameter int RAMP_MIN_CYC = 10000,
  parameter int PWM_PERIOD = 256
) (
  input wire logic clk,
  input wire logic rst_b,
  tgd_link_if.host link,
  input wire logic start,
  input wire logic reverse,
  input wire logic bemf_commutate,
  input wire logic accelerating,
  input wire logic [7:0] duty,
  output tgd_mode_t mode,
  output logic [2:0] step
);
  tgd_mode_t mode_reg, mode_next;
  logic [TGD_TIME_W-1:0] tmr_reg, period_reg;
  logic [2:0] step_reg;
  logic [7:0] pwm_reg;
  wire tmr_done = (tmr_reg == '0);
  wire pwm_on = (pwm_reg < duty);
  // six-step table, order decides direction
  logic [5:0] step_pat;
  always_comb begin
    case (step_reg)
      3'h0: step_pat = TGD_PAT_S1; // [R9]
      3'h1: step_pat = TGD_PAT_S2;
      3'h2: step_pat = TGD_PAT_S3;
      3'h3: step_pat = TGD_PAT_S4;
      3'h4: step_pat = TGD_PAT_S5;
      default: step_pat = TGD_PAT_S6;
    endcase
  end
  wire adv = (mode_reg == TGD_RAMP && tmr_done) || (mode_reg == TGD_RUN && bemf_commutate);
  // chop-coast: gate high sides only; chop-chop: gate both sides
  wire [5:0] chop = accelerating ? {6{pwm_on}} : {{3{pwm_on}}, 3'h7}; // [R18] [R19]
  logic [5:0] pat;
  always_comb begin
    case (mode_reg)
      TGD_BOOTSTRAP: pat = TGD_PAT_BOOT; // [R3] [R4]
      TGD_LOCK: pat = TGD_PAT_LOCK; // [R5]
      TGD_RAMP, TGD_RUN: pat = step_pat & chop;
      default: pat = TGD_PAT_OFF;
    endcase
  end
  // mode sequence
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      TGD_DISABLED: if (start) mode_next = TGD_BOOTSTRAP; // [R1]
      TGD_BOOTSTRAP: if (tmr_done) mode_next = TGD_LOCK; // [R3]
      TGD_LOCK: if (tmr_done) mode_next = TGD_RAMP; // [R6]
      TGD_RAMP: if (adv && period_reg <= TGD_TIME_W'(RAMP_MIN_CYC)) mode_next = TGD_RUN; // [R7]
      TGD_RUN: mode_next = TGD_RUN; // [R8]
      default: mode_next = TGD_DISABLED;
    endcase
    if (!start) mode_next = TGD_DISABLED;
  end
  always_ff @(posedge clk) begin
    if (!rst_b) mode_reg <= TGD_DISABLED;
    else mode_reg <= mode_next;
  end
  // phase timer: bootstrap, lock and ramp step intervals
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tmr_reg <= '0;
      period_reg <= '0;
    end else if (mode_next != mode_reg) begin
      tmr_reg <= (mode_next == TGD_BOOTSTRAP) ? TGD_TIME_W'(BOOT_CYC) :
        (mode_next == TGD_LOCK) ? TGD_TIME_W'(LOCK_CYC) : TGD_TIME_W'(RAMP_START_CYC);
      period_reg <= TGD_TIME_W'(RAMP_START_CYC);
    end else if (mode_reg == TGD_RAMP && tmr_done) begin
      // linear speed-up: shorten each step interval
      period_reg <= period_reg - TGD_TIME_W'(RAMP_DEC_CYC); // [R7]
      tmr_reg <= period_reg - TGD_TIME_W'(RAMP_DEC_CYC);
    end else if (!tmr_done) begin
      tmr_reg <= tmr_reg - 1'b1;
    end
  end
  // commutation step counter; direction from reverse input
  always_ff @(posedge clk) begin
    if (!rst_b || mode_reg == TGD_LOCK) step_reg <= TGD_STEP_FIRST;
    else if (adv && !reverse) step_reg <= (step_reg == TGD_STEP_LAST) ? TGD_STEP_FIRST : step_reg + 1'b1; // [R9]
    else if (adv) step_reg <= (step_reg == TGD_STEP_FIRST) ? TGD_STEP_LAST : step_reg - 1'b1; // [R9]
  end
  always_ff @(posedge clk) begin
    if (!rst_b) pwm_reg <= '0;
    else pwm_reg <= (pwm_reg == 8'(PWM_PERIOD - 1)) ? 8'h00 : pwm_reg + 8'h01;
  end
  // registered pins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      link.high_drive <= '0;
      link.low_drive <= '0;
      link.chip_enable <= 1'b0;
    end else begin
      link.high_drive <= pat[5:3];
      link.low_drive <= pat[2:0];
      // enable follows the current mode so it rises together with the bootstrap pattern
      link.chip_enable <= (mode_reg != TGD_DISABLED); // [R2]
    end
  end
  assign mode = mode_reg;
  assign step = step_reg;
endmodule : tgd_host
`default_nettype wire

// File: testbench/tgd_link_monitor.sv
// checker: rules seen on the link between host and driver ends
`timescale 1ns/1ps
`default_nettype none
module tgd_link_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [2:0] high_drive,
  input wire logic [2:0] low_drive,
  input wire logic chip_enable,
  input wire logic fault_out_oe,
  input wire logic fault_output_pin
);
  logic [3:0] age_reg;
  // cycles since enable was last low; saturates so it never wraps
  always_ff @(posedge clk) begin
    if (!rst_b || !chip_enable) age_reg <= 4'h0;
    else if (age_reg != 4'hf) age_reg <= age_reg + 4'h1;
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_b);
  idle_drive_a: assert property (!chip_enable |-> (high_drive | low_drive) == 3'h0)
    else $error("drive while disabled");
  boot_first_a: assert property ($rose(chip_enable) |->
    (low_drive == 3'h7 && high_drive == 3'h0) [*8])
    else $error("bad bootstrap start");
  lock_next_a: assert property (chip_enable && $past(low_drive) == 3'h7 && low_drive != 3'h7
    |-> high_drive == 3'h5 && low_drive == 3'h2)
    else $error("bad lock pattern");
  no_overlap_a: assert property ((high_drive & low_drive) == 3'h0)
    else $error("both sides driven");
  pin_level_a: assert property (fault_output_pin == !fault_out_oe)
    else $error("fault pin level");
  fault_hold_a: assert property (chip_enable [*6] ##0 fault_out_oe |=> fault_out_oe)
    else $error("fault lost");
  fault_clear_a: assert property ($fell(fault_out_oe) |-> age_reg <= 4'h8)
    else $error("fault cleared early");
  idle_fault_a: assert property (!chip_enable [*8] |-> !fault_out_oe)
    else $error("fault while idle");
endmodule : tgd_link_monitor
`default_nettype wire

// File: testbench/three_phase_gate_drive_control_bench.sv
// testbench: host and driver ends joined over their link
`timescale 1ns/1ps
`default_nettype none
module three_phase_gate_drive_control_bench;
  import tgd_pkg::*;
  logic clk = 1'b0;
  logic rst_b, start, reverse, bemf_commutate, accelerating, gate_undervoltage_enable;
  logic [7:0] duty;
  logic [2:0] dead_time_select, high_bias_low, low_bias_low, step, high_gate, low_gate;
  logic driver_fault;
  tgd_mode_t mode;
  logic [31:0] lfsr = 32'h7b205e19;
  logic [6:0] note_q [$];
  logic [6:0] nt;
  logic [5:0] last_ms = 6'h0;
  logic [5:0] pat;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;
  int k, s;
  localparam logic [5:0] STEP_PAT [6] = '{TGD_PAT_S1, TGD_PAT_S2, TGD_PAT_S3, TGD_PAT_S4,
    TGD_PAT_S5, TGD_PAT_S6};
  always #4 clk = ~clk;
  tgd_link_if link ();
  tgd_host #(.BOOT_CYC(150), .LOCK_CYC(200), .RAMP_START_CYC(60), .RAMP_DEC_CYC(20),
    .RAMP_MIN_CYC(20)) i_tgd_host (.clk(clk), .rst_b(rst_b), .link(link), .start(start),
    .reverse(reverse), .bemf_commutate(bemf_commutate), .accelerating(accelerating),
    .duty(duty), .mode(mode), .step(step));
  tgd_driver i_tgd_driver (.clk(clk), .rst_b(rst_b), .link(link),
    .dead_time_select(dead_time_select), .gate_undervoltage_enable(gate_undervoltage_enable),
    .high_bias_low(high_bias_low), .low_bias_low(low_bias_low), .high_gate(high_gate),
    .low_gate(low_gate), .driver_fault(driver_fault));
  tgd_link_monitor i_tgd_link_monitor (.clk(clk), .rst_b(rst_b), .high_drive(link.high_drive),
    .low_drive(link.low_drive), .chip_enable(link.chip_enable),
    .fault_out_oe(link.fault_out_oe), .fault_output_pin(link.fault_output_pin));
  function automatic logic [31:0] rnd(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : rnd
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_sim;
    if (n_mismatch == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic note(input tgd_mode_t m);
    note_q.push_back({1'b0, m, 3'h0});
  endtask : note
  // bounded wait; a hang here shows up as a wrong mode
  task automatic wait_mode(input tgd_mode_t m);
    for (int i = 0; i < 2000 && mode !== m; i++) cyc(1);
    check({5'h0, mode}, {5'h0, m}, "mode reached");
  endtask : wait_mode
  // watcher: a mode change, or a step change in run, retires the oldest note
  always @(posedge clk) begin
    if (rst_b && {mode, step} != last_ms && (mode != last_ms[5:3] || mode == TGD_RUN)) begin
      if (note_q.size() == 0) check(8'h0, 8'h1, "extra event");
      else begin
        nt = note_q.pop_front();
        check({5'h0, mode}, {5'h0, nt[5:3]}, "mode");
        if (nt[6]) check({5'h0, step}, {5'h0, nt[2:0]}, "step");
      end
    end
    last_ms <= {mode, step};
    cycles++;
    if (cycles == 8000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    {rst_b, start, reverse, bemf_commutate, accelerating, gate_undervoltage_enable} = '0;
    {dead_time_select, high_bias_low, low_bias_low} = '0;
    duty = 8'hff;
    cyc(12);
    rst_b = 1'b1;
    lfsr = rnd(lfsr);
    dead_time_select = {2'h0, lfsr[0]};
    duty = {2'h3, lfsr[8:3]};
    note(TGD_BOOTSTRAP);
    note(TGD_LOCK);
    note(TGD_RAMP);
    note(TGD_RUN);
    start = 1'b1;
    wait_mode(TGD_BOOTSTRAP);
    for (k = 0; k < 400 && mode === TGD_BOOTSTRAP; k++) begin
      cyc(1);
      if (k == 60) check({2'h0, high_gate, low_gate}, {2'h0, TGD_PAT_BOOT}, "boot");
    end
    check({7'h0, k >= 148 && k <= 152}, 8'h1, "boot hold");
    // bias low only on drivers that lock leaves idle
    low_bias_low = 3'h1;
    high_bias_low = 3'h2;
    gate_undervoltage_enable = 1'b1;
    for (k = 0; k < 300 && high_gate[0] !== 1'b1; k++) cyc(1);
    s = (dead_time_select + 1) * TGD_DEAD_STEP_CYC;
    check({7'h0, k >= s && k <= s + 12}, 8'h1, "dead time");
    cyc(60);
    check({1'b0, driver_fault, high_gate, low_gate}, {2'h0, TGD_PAT_LOCK}, "lock");
    {high_bias_low, low_bias_low} = '0;
    wait_mode(TGD_RUN);
    for (int i = 0; i < 12; i++) begin
      lfsr = rnd(lfsr);
      accelerating = lfsr[0];
      reverse = (i >= 6);
      s = step;
      s = reverse ? (s + 5) % 6 : (s + 1) % 6;
      note_q.push_back({1'b1, TGD_RUN, s[2:0]});
      bemf_commutate = 1'b1;
      cyc(1);
      bemf_commutate = 1'b0;
      cyc(40);
      pat = STEP_PAT[s];
      check({2'h0, link.high_drive, link.low_drive} & ~{2'h3, pat}, 8'h0, "drive");
      check({2'h0, high_gate, low_gate} & ~{2'h3, pat}, 8'h0, "gates");
      if (!accelerating) check({5'h0, link.low_drive}, {5'h0, pat[2:0]}, "coast");
    end
    accelerating = 1'b0;
    note(TGD_DISABLED);
    low_bias_low = 3'h7;
    for (k = 0; k < 200 && driver_fault !== 1'b1; k++) cyc(1);
    check({7'h0, k >= TGD_BIAS_FILTER_CYC && k < TGD_BIAS_FILTER_CYC + 20}, 8'h1, "filter");
    cyc(2);
    check({1'b0, link.fault_output_pin, high_gate, low_gate}, 8'h0, "fault");
    low_bias_low = 3'h0;
    cyc(20);
    check({7'h0, driver_fault}, 8'h1, "latch");
    start = 1'b0;
    cyc(20);
    check({1'b0, driver_fault, high_gate, low_gate}, 8'h0, "off");
    gate_undervoltage_enable = 1'b0;
    low_bias_low = 3'h7;
    note(TGD_BOOTSTRAP);
    note(TGD_LOCK);
    start = 1'b1;
    wait_mode(TGD_LOCK);
    cyc(100);
    check({1'b0, driver_fault, high_gate, low_gate}, {2'h0, TGD_PAT_LOCK}, "no uv");
    note(TGD_DISABLED);
    start = 1'b0;
    cyc(20);
    end_sim();
  end
endmodule : three_phase_gate_drive_control_bench
`default_nettype wire
